// ==== dv/ipcic_host.sv ====
`timescale 1ns/1ps
module ipcic_host (
    input wire logic [1:0] out_i,    // Device pad values
    input wire logic [1:0] oe_i,     // Device pad enables
    input wire logic [1:0] drv_en_i, // Host drives the pad
    input wire logic [1:0] drv_i,    // Host pad value
    output logic [1:0] pad_o         // Resolved pad level
);
    // Pull-up holds an undriven line high
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (oe_i[i]) begin
                pad_o[i] = out_i[i];
            end else if (drv_en_i[i]) begin
                pad_o[i] = drv_i[i];
            end else begin
                pad_o[i] = 1'b1;
            end
        end
    end
endmodule

// ==== dv/tb_irq_pin_config_and_init_ctrl.sv ====
`timescale 1ns/1ps
module tb_irq_pin_config_and_init_ctrl;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic we = 1'b0;
    logic re = 1'b0;
    logic clr = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [2:0] ev = 3'h0;
    logic [1:0] drv_en = 2'h0;
    logic [1:0] drv = 2'h0;
    logic [1:0] pad, pout, poe, trig, asrt;
    logic [7:0] rdata, ca, d, fm1, fm2;
    logic feat, load, start;
    logic [11:0] base;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    string nm_q[$];
    int bad_count = 0;
    int checks_done = 0;
    int seed = 74;
    logic [7:0] ra[10];
    logic [7:0] rr[10];
    logic [7:0] rm[10];

    always #10 clk = ~clk;

    ipcic_top dut_u (
        .MCLK_I(clk), .NRST_I(nrst), .CE_I(ce), .REG_ADDR_I(addr),
        .REG_WE_I(we), .REG_WDATA_I(wdata), .REG_RE_I(re),
        .REG_RDATA_O(rdata), .FIFO_FULL_I(ev[0]), .FIFO_WM_I(ev[1]),
        .DRDY_I(ev[2]), .INT_CLR_I(clr), .IRQ_PIN_IN_I(pad),
        .IRQ_PIN_OUT_O(pout), .IRQ_PIN_OE_O(poe), .IRQ_TRIG_O(trig),
        .IRQ_ASSERT_O(asrt), .FMAP_ONE_O(fm1), .FMAP_TWO_O(fm2),
        .CFG_LOAD_O(load), .FEAT_EN_O(feat), .INIT_START_O(start),
        .INIT_BASE_O(base)
    );

    ipcic_host host_u (
        .out_i(pout), .oe_i(poe), .drv_en_i(drv_en), .drv_i(drv),
        .pad_o(pad)
    );

    task automatic chk(input string n, input logic [11:0] s,
                       input logic [11:0] e);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s exp=%h seen=%h", n, e, s);
        end
    endtask

    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wdata = v;
        @(negedge clk);
        we = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string n);
        @(negedge clk);
        re = 1'b1;
        addr = a;
        exp_q.push_back(e);
        nm_q.push_back(n);
        @(negedge clk);
        re = 1'b0;
    endtask

    task automatic do_reset();
        nrst = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 10; i++) rd(ra[i], rr[i], "reset");
    endtask

    // Read data lands one cycle after the strobe is taken
    always @(posedge clk) rd_seen <= re && ce && nrst;
    always @(negedge clk) begin
        if (rd_seen) begin
            chk(nm_q.pop_front(), 12'(rdata), 12'(exp_q.pop_front()));
        end
    end

    function automatic logic [1:0] pin_exp(input logic [7:0] c,
                                           input logic a);
        if (!c[3]) begin
            return 2'b00;
        end
        if (!c[2]) begin
            return {1'b1, a ? c[1] : !c[1]};
        end
        return {a ? !c[1] : c[1], 1'b0};
    endfunction

    initial begin
        ra = '{ipcic_pkg::ADDR_CTL_ONE, ipcic_pkg::ADDR_CTL_TWO,
               ipcic_pkg::ADDR_LATCH, ipcic_pkg::ADDR_FMAP_ONE,
               ipcic_pkg::ADDR_FMAP_TWO, ipcic_pkg::ADDR_DMAP,
               ipcic_pkg::ADDR_CMD, ipcic_pkg::ADDR_BASE_LO,
               ipcic_pkg::ADDR_BASE_HI, 8'h5a};
        rr = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h90, 8'h00,
               8'h00, 8'h00};
        rm = '{8'h1f, 8'h1f, 8'h01, 8'hff, 8'hff, 8'h77, 8'hff, 8'h0f,
               8'hff, 8'h00};
        do_reset();
        ce = 1'b0;
        wr(ipcic_pkg::ADDR_CTL_ONE, 8'h1f);
        ce = 1'b1;
        rd(ipcic_pkg::ADDR_CTL_ONE, 8'h00, "ce_freeze");
        // Early start is refused; then load and start once each
        wr(ipcic_pkg::ADDR_CMD, 8'h01);
        chk("early_start", {9'h0, feat, load, start}, 12'h0);
        rd(ipcic_pkg::ADDR_CMD, 8'h01, "cmd_kept");
        wr(ipcic_pkg::ADDR_CMD, 8'h00);
        chk("load_mode", {9'h0, feat, load, start}, 12'h2);
        wr(ipcic_pkg::ADDR_CMD, 8'h01);
        chk("start", {9'h0, feat, load, start}, 12'h5);
        @(negedge clk);
        chk("start_pulse", {9'h0, feat, load, start}, 12'h4);
        chk("base_untouched", base, 12'h000);
        // Bursts of 40 bytes move the base by 20 words
        for (logic [11:0] b = 12'h0f8; b < 12'h134; b += 12'd20) begin
            wr(ipcic_pkg::ADDR_BASE_LO, {4'h0, b[3:0]});
            wr(ipcic_pkg::ADDR_BASE_HI, b[11:4]);
            chk("base", base, b);
        end
        for (int i = 0; i < 10; i++) begin
            d = 8'($random(seed));
            wr(ra[i], d);
            if (i == 3) chk("fmap_one", 12'(fm1), 12'(d));
            if (i == 4) chk("fmap_two", 12'(fm2), 12'(d));
            rd(ra[i], d & rm[i], "rand_rw");
        end
        chk("run_holds", {11'h0, feat}, 12'h1);
        wr(ipcic_pkg::ADDR_LATCH, 8'h00);
        for (int b = 0; b < 6; b++) begin
            wr(ipcic_pkg::ADDR_DMAP, 8'h01 << (b < 3 ? b : b + 1));
            ev = 3'h1 << (b % 3);
            @(negedge clk);
            chk("route", 12'(asrt), b < 3 ? 12'h1 : 12'h2);
            ev = ~(3'h1 << (b % 3));
            @(negedge clk);
            chk("no_route", 12'(asrt), 12'h0);
            ev = 3'h0;
        end
        wr(ipcic_pkg::ADDR_DMAP, 8'hff);
        rd(ipcic_pkg::ADDR_DMAP, 8'h77, "dmap_rsvd");
        for (int p = 0; p < 2; p++) begin
            ca = p ? ipcic_pkg::ADDR_CTL_TWO : ipcic_pkg::ADDR_CTL_ONE;
            for (int c = 0; c < 16; c++) begin
                wr(ca, 8'(c));
                for (int a = 0; a < 2; a++) begin
                    ev = 3'(a);
                    repeat (3) @(negedge clk);
                    d = {6'h0, pin_exp(8'(c), a[0])};
                    chk("pin_oe", 12'(poe[p]), 12'(d[1]));
                    if (d[1]) begin
                        chk("pin_out", 12'(pout[p]), 12'(d[0]));
                    end
                end
            end
            wr(ca, 8'h00);
        end
        ev = 3'h0;
        wr(ipcic_pkg::ADDR_LATCH, 8'h01);
        wr(ipcic_pkg::ADDR_DMAP, 8'h01);
        wr(ipcic_pkg::ADDR_CTL_ONE, 8'h0a);
        for (int l = 1; l >= 0; l--) begin
            wr(ipcic_pkg::ADDR_LATCH, 8'(l));
            ev = 3'h1;
            @(negedge clk);
            ev = 3'h0;
            repeat (3) @(negedge clk);
            chk("latched", 12'(asrt[0]), 12'(l));
            chk("latch_pin", 12'(pout[0]), 12'(l));
            clr = 1'b1;
            @(negedge clk);
            clr = 1'b0;
            chk("cleared", 12'(asrt[0]), 12'h0);
        end
        for (int p = 0; p < 2; p++) begin
            ca = p ? ipcic_pkg::ADDR_CTL_TWO : ipcic_pkg::ADDR_CTL_ONE;
            drv_en[p] = 1'b1;
            drv[p] = 1'b0;
            wr(ca, 8'h13);
            repeat (8) @(negedge clk);
            chk("trig_idle", 12'(trig[p]), 12'h0);
            drv[p] = 1'b1;
            repeat (4) @(negedge clk);
            chk("trig_edge", 12'(trig[p]), 12'h1);
            @(negedge clk);
            chk("trig_pulse", 12'(trig[p]), 12'h0);
            wr(ca, 8'h12);
            repeat (8) @(negedge clk);
            chk("trig_level", 12'(trig[p]), 12'h1);
            wr(ca, 8'h02);
            repeat (4) @(negedge clk);
            chk("trig_off", 12'(trig[p]), 12'h0);
            drv_en[p] = 1'b0;
        end
        do_reset();
        chk("reinit", {9'h0, feat, load, start}, 12'h0);
        repeat (2) @(negedge clk);
        complete_run();
    end

    // Whole run is near 510 cycles; the limit leaves wide margin
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
endmodule

// ==== logic/ipcic_pin.sv ====
`timescale 1ns/1ps
module ipcic_pin (
    input wire logic clk_i,          // Device clock
    input wire logic rst_n_i,        // Async reset, active low
    input wire logic ce_i,           // Clock enable
    input wire logic [7:0] ctl_i,    // Pin control register
    input wire logic assert_i,       // Interrupt asserted, active high
    input wire logic pin_i,          // Pin level from pad
    output logic out_o,              // Pin output value
    output logic oe_o,               // Pin output enable
    output logic trig_o              // Input trigger
);

    ipcic_pkg::ipcic_pin_t s_q;
    ipcic_pkg::ipcic_pin_t s_d;
    logic lvl;
    logic act_new;

    // Sync idles high like the pulled-up pad, so no false edge at start
    localparam ipcic_pkg::ipcic_pin_t PIN_RST = '{
        sync: '1,
        stable: 1'b1,
        act: 1'b0,
        trig: 1'b0,
        out: 1'b0,
        oe: 1'b0
    };

    assign lvl = ctl_i[ipcic_pkg::CTL_LVL];

    always_comb begin
        s_d = s_q;
        s_d.sync = {s_q.sync[ipcic_pkg::SYNC_DEPTH-2:0], pin_i};
        // Settle only when stages two and three agree
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.stable = s_q.sync[2];
        end
        act_new = (s_d.stable == lvl);
        s_d.act = act_new;
        if (!ctl_i[ipcic_pkg::CTL_IN_EN]) begin
            s_d.trig = 1'b0;
        end else if (ctl_i[ipcic_pkg::CTL_EDGE]) begin
            s_d.trig = act_new & ~s_q.act;
        end else begin
            s_d.trig = act_new;
        end
        if (ctl_i[ipcic_pkg::CTL_DRAIN_SEL]) begin
            s_d.out = 1'b0;
            s_d.oe = ctl_i[ipcic_pkg::CTL_OUT_EN] & (assert_i ^ lvl) ;
        end else begin
            s_d.out = lvl ? assert_i : ~assert_i;
            s_d.oe = ctl_i[ipcic_pkg::CTL_OUT_EN];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q <= PIN_RST;
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    assign out_o = s_q.out;
    assign oe_o = s_q.oe;
    assign trig_o = s_q.trig;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    pin_off_a: assert property (
        ce_i && !ctl_i[ipcic_pkg::CTL_OUT_EN] |=> !oe_o)
        else $error("pin driven while output disabled");

    drain_low_a: assert property (
        ce_i && ctl_i[ipcic_pkg::CTL_DRAIN_SEL]
        && ctl_i[ipcic_pkg::CTL_OUT_EN]
        |=> !out_o && (oe_o == $past(assert_i ^ lvl)))
        else $error("open drain pin drove wrong level");

    polarity_a: assert property (
        ce_i && !ctl_i[ipcic_pkg::CTL_DRAIN_SEL]
        |=> out_o == ($past(lvl) ? $past(assert_i) : !$past(assert_i)))
        else $error("push-pull pin polarity wrong");

    input_gate_a: assert property (
        ce_i && !ctl_i[ipcic_pkg::CTL_IN_EN] |=> !trig_o)
        else $error("trigger while input disabled");

    edge_once_a: assert property (
        ce_i && ctl_i[ipcic_pkg::CTL_EDGE] && trig_o |=> !trig_o)
        else $error("edge trigger longer than one cycle");

endmodule

// ==== logic/ipcic_pkg.sv ====
package ipcic_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CTL_ONE = 8'h53;
    localparam logic [7:0] ADDR_CTL_TWO = 8'h54;
    localparam logic [7:0] ADDR_LATCH = 8'h55;
    localparam logic [7:0] ADDR_FMAP_ONE = 8'h56;
    localparam logic [7:0] ADDR_FMAP_TWO = 8'h57;
    localparam logic [7:0] ADDR_DMAP = 8'h58;
    localparam logic [7:0] ADDR_CMD = 8'h59;
    localparam logic [7:0] ADDR_BASE_LO = 8'h5b;
    localparam logic [7:0] ADDR_BASE_HI = 8'h5c;

    // Pin control field positions
    localparam int CTL_EDGE = 0;
    localparam int CTL_LVL = 1;
    localparam int CTL_DRAIN_SEL = 2;
    localparam int CTL_OUT_EN = 3;
    localparam int CTL_IN_EN = 4;

    // Data event map and latch field positions
    localparam int DMAP_ONE_LSB = 0;
    localparam int DMAP_TWO_LSB = 4;
    localparam int LATCH_BIT = 0;

    // Writable bits; all others read as zero
    localparam logic [7:0] CTL_MASK = 8'h1f;
    localparam logic [7:0] LATCH_MASK = 8'h01;
    localparam logic [7:0] DMAP_MASK = 8'h77;
    localparam logic [7:0] BASE_LO_MASK = 8'h0f;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CMD = 8'h90;

    // Command codes
    localparam logic [7:0] CMD_LOAD = 8'h00;
    localparam logic [7:0] CMD_START = 8'h01;

    // Pin input synchroniser depth
    localparam int SYNC_DEPTH = 3;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b00,
        INIT_LOAD = 2'b01,
        INIT_RUN = 2'b10
    } ipcic_init_t;

    typedef struct packed {
        logic [7:0] ctl_one;
        logic [7:0] ctl_two;
        logic [7:0] latch;
        logic [7:0] fmap_one;
        logic [7:0] fmap_two;
        logic [7:0] dmap;
        logic [7:0] cmd;
        logic [7:0] base_lo;
        logic [7:0] base_hi;
        logic [1:0] evt;
        logic [1:0] sticky;
        ipcic_init_t st;
        logic start;
        logic [7:0] rdata;
    } ipcic_main_t;

    typedef struct packed {
        logic [SYNC_DEPTH-1:0] sync;
        logic stable;
        logic act;
        logic trig;
        logic out;
        logic oe;
    } ipcic_pin_t;

endpackage

// ==== logic/ipcic_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Pin one control bit0: level or edge trigger
// - Pin one control bit1: active low or high
// - Pin one control bit2: push-pull or open drain
// - Pin one control bit3: output disabled or driven
// - Pin one control bit4: input ignored or accepted
// - Pin two has identical control, resets zero
// - Latch bit0: follows the routed event level or held until cleared
// - Event map bits 0-2 route to pin one
// - Event map bits 4-6 route to pin two
// - Command 0x00 enters configuration load mode
// - Command 0x01 starts features after load
// - Twelve-bit base split over two registers
module ipcic_top (
    input wire logic MCLK_I,             // 50 MHz device clock
    input wire logic NRST_I,             // Async reset, active low
    input wire logic CE_I,               // Clock enable, freezes state
    input wire logic [7:0] REG_ADDR_I,   // Register address
    input wire logic REG_WE_I,           // Write strobe
    input wire logic [7:0] REG_WDATA_I,  // Write data
    input wire logic REG_RE_I,           // Read strobe
    output logic [7:0] REG_RDATA_O,      // Read data, registered
    input wire logic FIFO_FULL_I,        // FIFO full event
    input wire logic FIFO_WM_I,          // FIFO watermark event
    input wire logic DRDY_I,             // Sample ready event
    input wire logic INT_CLR_I,          // Clear latched interrupts
    input wire logic [1:0] IRQ_PIN_IN_I, // Pad levels, bit0 pin one
    output logic [1:0] IRQ_PIN_OUT_O,    // Pad output values
    output logic [1:0] IRQ_PIN_OE_O,     // Pad output enables
    output logic [1:0] IRQ_TRIG_O,       // Input triggers from pins
    output logic [1:0] IRQ_ASSERT_O,     // Internal asserted state
    output logic [7:0] FMAP_ONE_O,       // Feature map for pin one
    output logic [7:0] FMAP_TWO_O,       // Feature map for pin two
    output logic CFG_LOAD_O,             // Config load mode active
    output logic FEAT_EN_O,              // Sensor features enabled
    output logic INIT_START_O,           // One-cycle start pulse
    output logic [11:0] INIT_BASE_O      // Config base address
);

    localparam ipcic_pkg::ipcic_main_t MAIN_RST = '{
        ctl_one: ipcic_pkg::RST_ZERO,
        ctl_two: ipcic_pkg::RST_ZERO,
        latch: ipcic_pkg::RST_ZERO,
        fmap_one: ipcic_pkg::RST_ZERO,
        fmap_two: ipcic_pkg::RST_ZERO,
        dmap: ipcic_pkg::RST_ZERO,
        cmd: ipcic_pkg::RST_CMD,
        base_lo: ipcic_pkg::RST_ZERO,
        base_hi: ipcic_pkg::RST_ZERO,
        evt: 2'h0,
        sticky: 2'h0,
        st: ipcic_pkg::INIT_IDLE,
        start: 1'b0,
        rdata: ipcic_pkg::RST_ZERO
    };

    ipcic_pkg::ipcic_main_t s_q;
    ipcic_pkg::ipcic_main_t s_d;
    logic [2:0] events;
    logic [1:0] hit;
    logic [1:0] asserted;
    logic [7:0] ctl [2];
    logic wr_cmd;

    assign events = {DRDY_I, FIFO_WM_I, FIFO_FULL_I};
    assign wr_cmd = REG_WE_I && (REG_ADDR_I == ipcic_pkg::ADDR_CMD);

    // Per-pin routing of data events
    assign hit[0] = |(events & s_q.dmap[ipcic_pkg::DMAP_ONE_LSB +: 3]);
    assign hit[1] = |(events & s_q.dmap[ipcic_pkg::DMAP_TWO_LSB +: 3]);

    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        if (REG_WE_I) begin
            case (REG_ADDR_I)
                ipcic_pkg::ADDR_CTL_ONE: begin
                    s_d.ctl_one = REG_WDATA_I & ipcic_pkg::CTL_MASK;
                end
                ipcic_pkg::ADDR_CTL_TWO: begin
                    s_d.ctl_two = REG_WDATA_I & ipcic_pkg::CTL_MASK;
                end
                ipcic_pkg::ADDR_LATCH: begin
                    s_d.latch = REG_WDATA_I & ipcic_pkg::LATCH_MASK;
                end
                ipcic_pkg::ADDR_FMAP_ONE: begin
                    s_d.fmap_one = REG_WDATA_I;
                end
                ipcic_pkg::ADDR_FMAP_TWO: begin
                    s_d.fmap_two = REG_WDATA_I;
                end
                ipcic_pkg::ADDR_DMAP: begin
                    s_d.dmap = REG_WDATA_I & ipcic_pkg::DMAP_MASK;
                end
                ipcic_pkg::ADDR_CMD: begin
                    s_d.cmd = REG_WDATA_I;
                end
                ipcic_pkg::ADDR_BASE_LO: begin
                    s_d.base_lo = REG_WDATA_I & ipcic_pkg::BASE_LO_MASK;
                end
                ipcic_pkg::ADDR_BASE_HI: begin
                    s_d.base_hi = REG_WDATA_I;
                end
                default: begin
                    s_d.cmd = s_q.cmd;
                end
            endcase
        end

        // Repeated or out-of-order commands leave the sequence alone
        case (s_q.st)
            ipcic_pkg::INIT_IDLE: begin
                if (wr_cmd && REG_WDATA_I == ipcic_pkg::CMD_LOAD) begin
                    s_d.st = ipcic_pkg::INIT_LOAD;
                end
            end
            ipcic_pkg::INIT_LOAD: begin
                if (wr_cmd && REG_WDATA_I == ipcic_pkg::CMD_START) begin
                    s_d.st = ipcic_pkg::INIT_RUN;
                    s_d.start = 1'b1;
                end
            end
            ipcic_pkg::INIT_RUN: begin
                s_d.st = ipcic_pkg::INIT_RUN;
            end
            default: begin
                s_d.st = ipcic_pkg::INIT_IDLE;
            end
        endcase

        s_d.evt = hit;
        // Set wins over clear so a colliding event is kept
        if (s_d.latch[ipcic_pkg::LATCH_BIT]) begin
            s_d.sticky = hit | (s_q.sticky & {2{~INT_CLR_I}});
        end else begin
            s_d.sticky = 2'h0;
        end

        if (REG_RE_I) begin
            case (REG_ADDR_I)
                ipcic_pkg::ADDR_CTL_ONE: s_d.rdata = s_q.ctl_one;
                ipcic_pkg::ADDR_CTL_TWO: s_d.rdata = s_q.ctl_two;
                ipcic_pkg::ADDR_LATCH: s_d.rdata = s_q.latch;
                ipcic_pkg::ADDR_FMAP_ONE: s_d.rdata = s_q.fmap_one;
                ipcic_pkg::ADDR_FMAP_TWO: s_d.rdata = s_q.fmap_two;
                ipcic_pkg::ADDR_DMAP: s_d.rdata = s_q.dmap;
                ipcic_pkg::ADDR_CMD: s_d.rdata = s_q.cmd;
                ipcic_pkg::ADDR_BASE_LO: s_d.rdata = s_q.base_lo;
                ipcic_pkg::ADDR_BASE_HI: s_d.rdata = s_q.base_hi;
                default: s_d.rdata = ipcic_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_q <= MAIN_RST;
        end else if (CE_I) begin
            s_q <= s_d;
        end
    end

    // Latched mode shows the sticky flag, else the routed event level
    assign asserted = s_q.latch[ipcic_pkg::LATCH_BIT] ? s_q.sticky : s_q.evt;
    assign ctl[0] = s_q.ctl_one;
    assign ctl[1] = s_q.ctl_two;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            ipcic_pin u_pin (
                .clk_i(MCLK_I),
                .rst_n_i(NRST_I),
                .ce_i(CE_I),
                .ctl_i(ctl[g]),
                .assert_i(asserted[g]),
                .pin_i(IRQ_PIN_IN_I[g]),
                .out_o(IRQ_PIN_OUT_O[g]),
                .oe_o(IRQ_PIN_OE_O[g]),
                .trig_o(IRQ_TRIG_O[g])
            );
        end
    endgenerate

    assign REG_RDATA_O = s_q.rdata;
    assign IRQ_ASSERT_O = asserted;
    assign FMAP_ONE_O = s_q.fmap_one;
    assign FMAP_TWO_O = s_q.fmap_two;
    assign CFG_LOAD_O = (s_q.st == ipcic_pkg::INIT_LOAD);
    assign FEAT_EN_O = (s_q.st == ipcic_pkg::INIT_RUN);
    assign INIT_START_O = s_q.start;
    assign INIT_BASE_O = {s_q.base_hi, s_q.base_lo[3:0]};

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    sequence load_write_s;
        CE_I && wr_cmd && REG_WDATA_I == ipcic_pkg::CMD_LOAD;
    endsequence

    sequence start_write_s;
        CE_I && wr_cmd && REG_WDATA_I == ipcic_pkg::CMD_START;
    endsequence

    load_mode_a: assert property (
        load_write_s and s_q.st == ipcic_pkg::INIT_IDLE
        |=> CFG_LOAD_O && !FEAT_EN_O)
        else $error("load command did not enter load mode");

    start_init_a: assert property (
        start_write_s and s_q.st == ipcic_pkg::INIT_LOAD
        |=> INIT_START_O && FEAT_EN_O && !CFG_LOAD_O)
        else $error("start command did not enable features");

    start_guard_a: assert property (
        $rose(FEAT_EN_O) |-> $past(CFG_LOAD_O) && INIT_START_O)
        else $error("features enabled without load");

    start_pulse_a: assert property (
        CE_I && INIT_START_O |=> !INIT_START_O)
        else $error("start pulse longer than one cycle");

    base_low_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_BASE_LO
        |=> INIT_BASE_O[3:0] == $past(REG_WDATA_I[3:0])
            && s_q.base_lo[7:4] == 4'h0)
        else $error("base low nibble not stored");

    base_high_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_BASE_HI
        |=> INIT_BASE_O[11:4] == $past(REG_WDATA_I))
        else $error("base high byte not stored");

    latch_hold_a: assert property (
        CE_I && s_q.latch[ipcic_pkg::LATCH_BIT] && asserted[0]
        && !INT_CLR_I && !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_LATCH)
        |=> asserted[0])
        else $error("latched interrupt dropped without clear");

    unlatched_a: assert property (
        CE_I && !s_q.latch[ipcic_pkg::LATCH_BIT] && !hit[1]
        && !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_LATCH)
        |=> !asserted[1])
        else $error("non-latched interrupt held");

    route_one_a: assert property (
        CE_I && FIFO_FULL_I && s_q.dmap[0]
        |=> asserted[0])
        else $error("fifo full not routed to pin one");

    route_two_a: assert property (
        CE_I && DRDY_I && s_q.dmap[6]
        |=> asserted[1])
        else $error("sample ready not routed to pin two");

    reserved_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_DMAP
        |=> s_q.dmap[3] == 1'b0 && s_q.dmap[7] == 1'b0)
        else $error("reserved map bits stored");

    readback_a: assert property (
        CE_I && REG_RE_I && REG_ADDR_I == ipcic_pkg::ADDR_CTL_TWO
        && !REG_WE_I |=> REG_RDATA_O == $past(s_q.ctl_two)
        && REG_RDATA_O[7:5] == 3'h0)
        else $error("pin two control readback wrong");

    sequence clear_s;
        CE_I && INT_CLR_I && s_q.latch[ipcic_pkg::LATCH_BIT];
    endsequence

    idle_refuse_a: assert property (
        start_write_s and s_q.st == ipcic_pkg::INIT_IDLE
        |=> !FEAT_EN_O && !INIT_START_O && !CFG_LOAD_O)
        else $error("start accepted before load");

    load_hold_a: assert property (
        CE_I && CFG_LOAD_O
        && !(wr_cmd && REG_WDATA_I == ipcic_pkg::CMD_START)
        |=> CFG_LOAD_O && !FEAT_EN_O)
        else $error("load mode left without start");

    run_hold_a: assert property (
        FEAT_EN_O |=> FEAT_EN_O && !CFG_LOAD_O)
        else $error("features dropped while running");

    cmd_store_a: assert property (
        CE_I && wr_cmd |=> s_q.cmd == $past(REG_WDATA_I))
        else $error("command value not stored");

    ctl_mask_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_CTL_ONE
        |=> s_q.ctl_one == ($past(REG_WDATA_I) & ipcic_pkg::CTL_MASK))
        else $error("pin one control bits wrong");

    latch_mask_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_LATCH
        |=> s_q.latch == ($past(REG_WDATA_I) & ipcic_pkg::LATCH_MASK))
        else $error("latch mode bits wrong");

    clear_drop_a: assert property (
        clear_s and !hit[0]
        and !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_LATCH)
        |=> !asserted[0])
        else $error("latched interrupt not cleared");

    route_wm_a: assert property (
        CE_I && FIFO_WM_I && s_q.dmap[1] |=> asserted[0])
        else $error("watermark not routed to pin one");

    full_two_a: assert property (
        CE_I && FIFO_FULL_I && s_q.dmap[4] |=> asserted[1])
        else $error("fifo full not routed to pin two");

    unlatched_one_a: assert property (
        CE_I && !s_q.latch[ipcic_pkg::LATCH_BIT] && !hit[0]
        && !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_LATCH)
        |=> !asserted[0])
        else $error("non-latched pin one interrupt held");

    unmapped_rd_a: assert property (
        CE_I && REG_RE_I && REG_ADDR_I > ipcic_pkg::ADDR_CMD
        && REG_ADDR_I < ipcic_pkg::ADDR_BASE_LO |=> REG_RDATA_O == 8'h00)
        else $error("unmapped read not zero");

    base_keep_a: assert property (
        !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_BASE_LO)
        && !(REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_BASE_HI)
        |=> $stable(INIT_BASE_O))
        else $error("base address changed without write");

    rd_keep_a: assert property (
        !REG_RE_I |=> $stable(REG_RDATA_O))
        else $error("read data changed without read");

    pulse_gate_a: assert property (
        INIT_START_O |-> FEAT_EN_O)
        else $error("start pulse outside run state");

    dmap_mask_a: assert property (
        CE_I && REG_WE_I && REG_ADDR_I == ipcic_pkg::ADDR_DMAP
        |=> s_q.dmap == ($past(REG_WDATA_I) & ipcic_pkg::DMAP_MASK))
        else $error("event map bits wrong");

endmodule
